// file: logic/mfa_arbiter.sv
// Measurement fault arbiter with AXI4-Lite register slave and interrupt
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "mfa_defs.svh"

// How it works
// - Failed measurement shows a fault and raises the error line; out-of-range does not.
// - Positive over-range forces judgement High, negative over-range forces Low.
// - Both probe-pair resistances checked against limits; contact fault names the side.
// - Sense-voltage instability during the measurement flags a voltage fault.
// - Contact or voltage fault shows, suppresses judgement, raises error, current ignored.
// - All checks passing presents the value and judges it against thresholds.
// - Failure to establish regulated current raises a current-monitor fault.
// - Current fault alone reports positive over-range and forces judgement High.
// - Over-range on range excess, deviation past 999.999%, display overflow or converter overflow.
// - Checks run in fixed order; only the first fault is reported and driven out.
// - Any settings change shows no-result until the next measurement completes.
// - Contact monitoring spans start of integration through end of measurement.
module mfa_arbiter #(
	parameter mfa_pkg::mfa_order_t CHECK_ORDER = 8'hE4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Measurement engine, same clock domain
	input wire logic meas_start_i,
	input wire logic meas_end_i,
	input wire logic [15:0] high_side_res_i,
	input wire logic [15:0] low_side_res_i,
	input wire logic volt_unstable_i,
	input wire logic cur_regulated_i,
	input wire logic adc_overflow_i,
	input wire logic zero_corr_overflow_i,
	input wire logic signed [31:0] value_i,
	input wire logic signed [31:0] deviation_i,
	input wire logic settings_change_i,
	// External control port
	output logic contact_fault_high_side_o,
	output logic contact_fault_low_side_o,
	output logic volt_fault_o,
	output logic cur_fault_o,
	output logic over_range_pos_o,
	output logic over_range_neg_o,
	output logic judge_hi_o,
	output logic judge_in_o,
	output logic judge_lo_o,
	output logic err_o,
	output logic no_result_o,
	output logic result_valid_o,
	output logic [2:0] fault_code_o,
	output logic irq_o,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import mfa_pkg::*;

	// ----------------------------------------------------------------
	// Registers and working signals
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q, contact_lim_q, upper_q, lower_q, range_max_q, value_q;
	logic [2:0] irq_stat_q, irq_mask_q, irq_set;
	logic aw_hold_q, w_hold_q, wr_en, wr_ok;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, wmask, rd_data;
	logic rd_ok;
	mfa_meas_e meas_q;
	logic in_win;
	logic hi_viol_q, lo_viol_q, volt_viol_q, cur_viol_q, adc_ovf_q;
	logic hi_viol_d, lo_viol_d, volt_viol_d, cur_viol_d, adc_ovf_d;
	logic eval;
	logic [3:0] fail;
	logic [1:0] winner;
	logic any_fail, ovr_neg, abs_over, dev_over;
	logic [31:0] mag;
	mfa_fault_e fault_d;
	logic settings_chg;

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	// Address and data are taken in either order; the write happens once both are held
	assign wr_en = aw_hold_q && w_hold_q && !s_axi_bvalid;
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[8*b +: 8] = {8{s_axi_wstrb[b]}};
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				s_axi_awready <= 1'b0;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				s_axi_wready <= 1'b0;
				wdata_q <= s_axi_wdata & wmask;
			end
			if (wr_en) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Decode of writable offsets; read-only offsets answer with an error on write
	always_comb begin
		unique case (awaddr_q)
			`MFA_OFF_CTRL, `MFA_OFF_CONTACT_LIM, `MFA_OFF_UPPER, `MFA_OFF_LOWER,
			`MFA_OFF_RANGE_MAX, `MFA_OFF_IRQ_STAT, `MFA_OFF_IRQ_MASK: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// Configuration registers; byte lanes not enabled were zeroed in wdata_q, so
	// a partial write clears unwritten bytes. Software should write whole words.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_q <= `MFA_CTRL_RST;
			contact_lim_q <= `MFA_CONTACT_LIM_RST;
			upper_q <= `MFA_UPPER_RST;
			lower_q <= `MFA_LOWER_RST;
			range_max_q <= `MFA_RANGE_MAX_RST;
			irq_mask_q <= `MFA_IRQ_MASK_RST;
		end else if (wr_en) begin
			unique case (awaddr_q)
				`MFA_OFF_CTRL: ctrl_q <= wdata_q;
				`MFA_OFF_CONTACT_LIM: contact_lim_q <= wdata_q;
				`MFA_OFF_UPPER: upper_q <= wdata_q;
				`MFA_OFF_LOWER: lower_q <= wdata_q;
				`MFA_OFF_RANGE_MAX: range_max_q <= wdata_q;
				`MFA_OFF_IRQ_MASK: irq_mask_q <= wdata_q[2:0];
				default: ;
			endcase
		end
	end

	// Writing any measurement setting counts as a settings change
	assign settings_chg = settings_change_i || (wr_en && (awaddr_q == `MFA_OFF_CTRL
		|| awaddr_q == `MFA_OFF_CONTACT_LIM || awaddr_q == `MFA_OFF_UPPER
		|| awaddr_q == `MFA_OFF_LOWER || awaddr_q == `MFA_OFF_RANGE_MAX));

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	always_comb begin
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			`MFA_OFF_CTRL: rd_data = ctrl_q;
			`MFA_OFF_CONTACT_LIM: rd_data = contact_lim_q;
			`MFA_OFF_UPPER: rd_data = upper_q;
			`MFA_OFF_LOWER: rd_data = lower_q;
			`MFA_OFF_RANGE_MAX: rd_data = range_max_q;
			`MFA_OFF_STATUS: rd_data = {20'h0_0000, meas_q, no_result_o, err_o, cur_fault_o,
				volt_fault_o, judge_hi_o, judge_in_o, judge_lo_o, 1'b0, fault_code_o};
			`MFA_OFF_IRQ_STAT: rd_data = {29'h0000_0000, irq_stat_q};
			`MFA_OFF_IRQ_MASK: rd_data = {29'h0000_0000, irq_mask_q};
			`MFA_OFF_VALUE: rd_data = value_q;
			default: begin
				rd_data = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Measurement window and sticky check results
	// ----------------------------------------------------------------
	// Window opens at start of integration and closes at end of measurement
	assign in_win = meas_start_i || meas_q == MFA_MS_INTEG;
	assign eval = in_win && meas_end_i;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meas_q <= MFA_MS_IDLE;
		end else if (eval) begin
			meas_q <= MFA_MS_IDLE;
		end else if (meas_start_i) begin
			meas_q <= MFA_MS_INTEG;
		end
	end

	// A fresh window starts from clean flags, checked every cycle of the window
	always_comb begin
		hi_viol_d = (meas_start_i ? 1'b0 : hi_viol_q) || (in_win && ctrl_q[`MFA_CTRL_CONTACT_EN]
			&& high_side_res_i > contact_lim_q[15:0]);
		lo_viol_d = (meas_start_i ? 1'b0 : lo_viol_q) || (in_win && ctrl_q[`MFA_CTRL_CONTACT_EN]
			&& low_side_res_i > contact_lim_q[31:16]);
		volt_viol_d = (meas_start_i ? 1'b0 : volt_viol_q) || (in_win
			&& ctrl_q[`MFA_CTRL_VOLT_EN] && volt_unstable_i);
		cur_viol_d = (meas_start_i ? 1'b0 : cur_viol_q) || (in_win && !cur_regulated_i);
		adc_ovf_d = (meas_start_i ? 1'b0 : adc_ovf_q) || (in_win && adc_overflow_i);
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			hi_viol_q <= 1'b0;
			lo_viol_q <= 1'b0;
			volt_viol_q <= 1'b0;
			cur_viol_q <= 1'b0;
			adc_ovf_q <= 1'b0;
		end else begin
			hi_viol_q <= hi_viol_d;
			lo_viol_q <= lo_viol_d;
			volt_viol_q <= volt_viol_d;
			cur_viol_q <= cur_viol_d;
			adc_ovf_q <= adc_ovf_d;
		end
	end

	// ----------------------------------------------------------------
	// Out-of-range detection and priority encoder
	// ----------------------------------------------------------------
	assign mag = value_i[31] ? 32'(-value_i) : value_i;
	assign abs_over = mag > range_max_q;
	assign dev_over = deviation_i > $signed(`MFA_DEV_LIMIT)
		|| deviation_i < -$signed(`MFA_DEV_LIMIT);
	assign ovr_neg = value_i[31];
	always_comb begin
		fail[MFA_CHK_CONTACT] = hi_viol_d || lo_viol_d;
		fail[MFA_CHK_VOLT] = volt_viol_d;
		fail[MFA_CHK_CUR] = cur_viol_d;
		fail[MFA_CHK_RANGE] = abs_over || dev_over || zero_corr_overflow_i || adc_ovf_d;
	end

	// Walk the order from last to first so the earliest failing check wins
	always_comb begin
		winner = 2'b00;
		any_fail = 1'b0;
		for (int i = 3; i >= 0; i--) begin
			if (fail[CHECK_ORDER[2*i +: 2]]) begin
				winner = CHECK_ORDER[2*i +: 2];
				any_fail = 1'b1;
			end
		end
	end

	// Map the winning check to the indication; high side is reported before low
	always_comb begin
		fault_d = MFA_FLT_NONE;
		if (any_fail) begin
			unique case (mfa_check_e'(winner))
				MFA_CHK_CONTACT: fault_d = hi_viol_d ? MFA_FLT_CONTACT_HI : MFA_FLT_CONTACT_LO;
				MFA_CHK_VOLT: fault_d = MFA_FLT_VOLT;
				MFA_CHK_CUR: fault_d = MFA_FLT_OVR_POS;
				MFA_CHK_RANGE: fault_d = ovr_neg ? MFA_FLT_OVR_NEG : MFA_FLT_OVR_POS;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Result outputs to the external control port
	// ----------------------------------------------------------------
	// Outputs hold from one result until the next, or until settings change
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || settings_chg) begin
			fault_code_o <= MFA_FLT_NO_RESULT;
			no_result_o <= 1'b1;
			{contact_fault_high_side_o, contact_fault_low_side_o} <= 2'b00;
			{volt_fault_o, cur_fault_o, over_range_pos_o, over_range_neg_o} <= 4'h0;
			{judge_hi_o, judge_in_o, judge_lo_o, err_o} <= 4'h0;
		end else if (eval) begin
			no_result_o <= 1'b0;
			fault_code_o <= fault_d;
			contact_fault_high_side_o <= fault_d == MFA_FLT_CONTACT_HI;
			contact_fault_low_side_o <= fault_d == MFA_FLT_CONTACT_LO;
			volt_fault_o <= fault_d == MFA_FLT_VOLT;
			cur_fault_o <= any_fail && winner == MFA_CHK_CUR;
			over_range_pos_o <= fault_d == MFA_FLT_OVR_POS;
			over_range_neg_o <= fault_d == MFA_FLT_OVR_NEG;
			// Only contact and voltage faults reach the error line
			err_o <= fault_d inside {MFA_FLT_CONTACT_HI, MFA_FLT_CONTACT_LO,
				MFA_FLT_VOLT};
			if (!ctrl_q[`MFA_CTRL_COMP_EN]) begin
				{judge_hi_o, judge_in_o, judge_lo_o} <= 3'b000;
			end else if (fault_d == MFA_FLT_OVR_POS) begin
				{judge_hi_o, judge_in_o, judge_lo_o} <= 3'b100;
			end else if (fault_d == MFA_FLT_OVR_NEG) begin
				{judge_hi_o, judge_in_o, judge_lo_o} <= 3'b001;
			end else if (fault_d != MFA_FLT_NONE) begin
				{judge_hi_o, judge_in_o, judge_lo_o} <= 3'b000;
			end else if (value_i > $signed(upper_q)) begin
				{judge_hi_o, judge_in_o, judge_lo_o} <= 3'b100;
			end else if (value_i < $signed(lower_q)) begin
				{judge_hi_o, judge_in_o, judge_lo_o} <= 3'b001;
			end else begin
				{judge_hi_o, judge_in_o, judge_lo_o} <= 3'b010;
			end
		end
	end

	// Measured value and completion pulse
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			value_q <= 32'h0000_0000;
			result_valid_o <= 1'b0;
		end else begin
			result_valid_o <= eval && !settings_chg;
			if (eval && fault_d == MFA_FLT_NONE) begin
				value_q <= value_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	// A new event in the clearing cycle survives: set is applied after clear
	assign irq_set = eval ? {fault_d inside {MFA_FLT_OVR_POS, MFA_FLT_OVR_NEG},
		fault_d inside {MFA_FLT_CONTACT_HI, MFA_FLT_CONTACT_LO, MFA_FLT_VOLT}, 1'b1} : 3'b000;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_stat_q <= 3'b000;
			irq_o <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~((wr_en && awaddr_q == `MFA_OFF_IRQ_STAT)
				? wdata_q[2:0] : 3'b000)) | irq_set;
			irq_o <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	range_no_err_a: assert property (eval && !settings_chg && fault_d inside
		{MFA_FLT_OVR_POS, MFA_FLT_OVR_NEG} |=> !err_o) else $error("error line on range");
	neg_forces_lo_a: assert property (eval && !settings_chg && fault_d == MFA_FLT_OVR_NEG
		&& ctrl_q[0] |=> judge_lo_o && !judge_hi_o) else $error("neg range not Lo");
	contact_side_a: assert property (eval && !settings_chg && hi_viol_d
		&& fail[winner] && winner == MFA_CHK_CONTACT |=> contact_fault_high_side_o
		&& !contact_fault_low_side_o) else $error("contact side wrong");
	volt_flag_a: assert property (in_win && !meas_end_i && ctrl_q[2] && volt_unstable_i
		|=> volt_viol_q) else $error("voltage instability lost");
	contact_err_a: assert property (eval && !settings_chg && (hi_viol_d || lo_viol_d)
		&& CHECK_ORDER[1:0] == MFA_CHK_CONTACT |=> err_o && !judge_hi_o && !judge_in_o
		&& !judge_lo_o) else $error("contact fault not reported");
	cur_high_a: assert property (eval && !settings_chg && any_fail && winner == MFA_CHK_CUR
		|=> cur_fault_o && over_range_pos_o && !err_o) else $error("current fault wrong");
	dev_range_a: assert property (deviation_i == 32'sh000F_4240 |-> fail[MFA_CHK_RANGE])
		else $error("deviation limit missed");
	one_fault_a: assert property ($onehot0({contact_fault_high_side_o, contact_fault_low_side_o,
		volt_fault_o, over_range_pos_o, over_range_neg_o})) else $error("two faults shown");
	no_result_a: assert property (settings_chg && !eval |=> no_result_o
		&& fault_code_o == MFA_FLT_NO_RESULT) else $error("no-result not shown");
	pass_judge_a: assert property (eval && !settings_chg && !any_fail && ctrl_q[0]
		|=> $onehot({judge_hi_o, judge_in_o, judge_lo_o}) && value_q == $past(value_i))
		else $error("pass result not judged");
	contact_span_a: assert property (meas_start_i && ctrl_q[1] && !meas_end_i
		&& high_side_res_i > contact_lim_q[15:0] |=> hi_viol_q) else $error("start missed");
	irq_level_a: assert property (|(irq_stat_q & irq_mask_q) |=> irq_o)
		else $error("irq not raised");

endmodule

// file: logic/mfa_defs.svh
// Register offsets, field positions, reset values and limits of the fault arbiter
`ifndef MFA_DEFS_SVH
`define MFA_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MFA_OFF_CTRL 8'h00
`define MFA_OFF_CONTACT_LIM 8'h04
`define MFA_OFF_UPPER 8'h08
`define MFA_OFF_LOWER 8'h0C
`define MFA_OFF_RANGE_MAX 8'h10
`define MFA_OFF_STATUS 8'h14
`define MFA_OFF_IRQ_STAT 8'h18
`define MFA_OFF_IRQ_MASK 8'h1C
`define MFA_OFF_VALUE 8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MFA_CTRL_COMP_EN 0
`define MFA_CTRL_CONTACT_EN 1
`define MFA_CTRL_VOLT_EN 2
`define MFA_IRQ_DONE 0
`define MFA_IRQ_ERR 1
`define MFA_IRQ_OVR 2

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define MFA_CTRL_RST 32'h0000_0007
`define MFA_CONTACT_LIM_RST 32'h0100_0100
`define MFA_UPPER_RST 32'h7FFF_FFFF
`define MFA_LOWER_RST 32'h0000_0000
`define MFA_RANGE_MAX_RST 32'h7FFF_FFFF
`define MFA_IRQ_MASK_RST 3'h0
// Relative deviation limit, 999.999 % in units of 0.001 %
`define MFA_DEV_LIMIT 32'h000F_423F

`endif

// file: logic/mfa_pkg.sv
// Types shared by the measurement fault arbiter
package mfa_pkg;

	// Fault indication shown for a finished measurement
	typedef enum logic [2:0] {
		MFA_FLT_NONE = 3'b000,
		MFA_FLT_CONTACT_HI = 3'b001,
		MFA_FLT_CONTACT_LO = 3'b010,
		MFA_FLT_VOLT = 3'b011,
		MFA_FLT_OVR_POS = 3'b100,
		MFA_FLT_OVR_NEG = 3'b101,
		MFA_FLT_NO_RESULT = 3'b110
	} mfa_fault_e;

	// Identity of each check, used to order the priority encoder
	typedef enum logic [1:0] {
		MFA_CHK_CONTACT = 2'b00,
		MFA_CHK_VOLT = 2'b01,
		MFA_CHK_CUR = 2'b10,
		MFA_CHK_RANGE = 2'b11
	} mfa_check_e;

	// Measurement window state
	typedef enum logic {
		MFA_MS_IDLE = 1'b0,
		MFA_MS_INTEG = 1'b1
	} mfa_meas_e;

	typedef logic [7:0] mfa_order_t;

endpackage

// file: tb/mfa_ctrl_model.sv
// Behavioural model of the production controller that reads the control port
`timescale 1ns/1ps
module mfa_ctrl_model (
	// Clock
	input wire logic clk_i,
	// Control port as seen by the controller
	input wire logic valid_i,
	input wire logic [2:0] code_i,
	input wire logic err_i,
	input wire logic [2:0] judge_i,
	input wire logic cur_i,
	input wire logic ovp_i,
	input wire logic ovn_i,
	// Latched view of one result
	output logic got_o,
	output logic [9:0] snap_o
);
	// ----------------------------------------------------------------
	// Latch on the result strobe
	// ----------------------------------------------------------------
	// A real controller only trusts the lines in the strobe cycle, so nothing else is kept
	always_ff @(posedge clk_i) begin
		got_o <= valid_i;
		if (valid_i) begin
			snap_o <= {code_i, err_i, judge_i, cur_i, ovp_i, ovn_i};
		end
	end
endmodule

// file: tb/tb.sv
// Self-checking bench of the measurement fault arbiter
`timescale 1ns/1ps
`include "mfa_defs.svh"
module tb;
	import mfa_pkg::*;
	// ----------------------------------------------------------------
	// Signals, model and design
	// ----------------------------------------------------------------
	logic clk, rst_n, st, en, vu, cr, ao, zc, got, sc;
	logic [15:0] hr, lr;
	logic signed [31:0] val, dev;
	logic [7:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic cfh, cfl, vf, cf, ovp, ovn, jh, ji, jl, err, nr, rv, irq;
	logic [2:0] fc;
	logic [9:0] snap, exp_v;
	logic [9:0] q[$];
	int err_total, cmp_count, cyc;
	integer seed;
	localparam logic [15:0] res_ok = 16'h0010;
	logic [7:0] r_off [6] = '{`MFA_OFF_CTRL, `MFA_OFF_CONTACT_LIM, `MFA_OFF_UPPER,
		`MFA_OFF_LOWER, `MFA_OFF_RANGE_MAX, `MFA_OFF_IRQ_MASK};
	logic [31:0] r_rst [6] = '{`MFA_CTRL_RST, `MFA_CONTACT_LIM_RST, `MFA_UPPER_RST,
		`MFA_LOWER_RST, `MFA_RANGE_MAX_RST, 32'(`MFA_IRQ_MASK_RST)};

	mfa_arbiter DUT (.clk_i(clk), .rst_n_i(rst_n), .meas_start_i(st), .meas_end_i(en),
		.high_side_res_i(hr), .low_side_res_i(lr), .volt_unstable_i(vu), .cur_regulated_i(cr),
		.adc_overflow_i(ao), .zero_corr_overflow_i(zc), .value_i(val), .deviation_i(dev),
		.settings_change_i(sc), .contact_fault_high_side_o(cfh),
		.contact_fault_low_side_o(cfl), .volt_fault_o(vf), .cur_fault_o(cf),
		.over_range_pos_o(ovp), .over_range_neg_o(ovn), .judge_hi_o(jh), .judge_in_o(ji),
		.judge_lo_o(jl), .err_o(err), .no_result_o(nr), .result_valid_o(rv),
		.fault_code_o(fc), .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	mfa_ctrl_model u_ctrl (.clk_i(clk), .valid_i(rv), .code_i(fc), .err_i(err),
		.judge_i({jh, ji, jl}), .cur_i(cf), .ovp_i(ovp), .ovn_i(ovn), .got_o(got),
		.snap_o(snap));

	// Clock at 200 MHz
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Compare, close and watchdog
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// A hang anywhere ends the run well after the expected run of about 240 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			test_done;
		end
	end

	// Oldest expectation against each result the controller latched
	always @(posedge clk) begin
		if (got) begin
			exp_v = q.size() ? q.pop_front() : 10'bx;
			chk(snap, exp_v);
			// Side and voltage lines still stand while the strobe is latched
			chk({cfh, cfl, vf}, {exp_v[9:7] == 3'h1, exp_v[9:7] == 3'h2,
				exp_v[9:7] == 3'h3});
		end
	end

	// Expected port image: error line only for contact and voltage faults
	function automatic logic [9:0] ex(mfa_fault_e c, logic [2:0] j, int cu);
		ex = {c, c inside {MFA_FLT_CONTACT_HI, MFA_FLT_CONTACT_LO, MFA_FLT_VOLT}, j, cu[0],
			c == MFA_FLT_OVR_POS, c == MFA_FLT_OVR_NEG};
	endfunction

	// ----------------------------------------------------------------
	// Drivers
	// ----------------------------------------------------------------
	// Flags f: bit0 unstable, bit1 no current, bit2 converter overflow, bit3 display overflow
	// Probe resistances go back to normal at the end cycle, so faults are seen mid-window
	task automatic meas(input logic [15:0] h, l, input logic [3:0] f,
		input logic signed [31:0] v, d, input logic [9:0] e);
		q.push_back(e);
		@(posedge clk);
		{st, hr, lr, vu, cr, ao, zc, val, dev} <= {1'b1, h, l, f[0], ~f[1], f[2], f[3], v, d};
		@(posedge clk);
		st <= 1'b0;
		@(posedge clk);
		{en, hr, lr} <= {1'b1, res_ok, res_ok};
		@(posedge clk);
		{en, vu, cr, ao, zc} <= 5'b0_0100;
		repeat (3) @(posedge clk);
	endtask

	// Handshakes are judged at the falling edge, acted on after the next rising edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic pa, pw, pb;
		logic [1:0] rsp;
		int n;
		@(posedge clk);
		{awaddr, awvalid, wdata, wvalid, bready} <= {a, 1'b1, d, 1'b1, 1'b1};
		pb = 1'b0;
		n = 0;
		while (!pb && n < 100) begin
			@(negedge clk);
			pa = awvalid && awready;
			pw = wvalid && wready;
			pb = bvalid && bready;
			rsp = bresp;
			n++;
			@(posedge clk);
			if (pa) awvalid <= 1'b0;
			if (pw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk({pb, rsp}, {1'b1, r});
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic pr;
		logic [1:0] rsp;
		logic [31:0] dat;
		int n;
		@(posedge clk);
		{araddr, arvalid, rready} <= {a, 1'b1, 1'b1};
		pr = 1'b0;
		n = 0;
		while (!pr && n < 100) begin
			@(negedge clk);
			pr = rvalid && rready;
			rsp = rresp;
			dat = rdata;
			n++;
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk({pr, rsp}, {1'b1, r});
		chk(dat, d);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'h75fe;
		{rst_n, st, en, vu, cr, ao, zc, hr, lr, val, dev} = {7'b0000100, res_ok, res_ok, 64'h0};
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = {8'h0, 1'b0, 32'h0, 4'hF, 2'b0};
		{araddr, arvalid, rready, sc} = 11'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk({nr, fc}, {1'b1, MFA_FLT_NO_RESULT});
		for (int i = 0; i < 6; i++) axi_rd(r_off[i], r_rst[i], 2'b00);
		meas(16'($random(seed)) & 16'h00FF, res_ok, 4'h0, $random(seed) & 32'h0000_7FFF, 0,
			ex(MFA_FLT_NONE, 3'b010, 1'b0));
		chk(nr, 1'b0);
		meas(16'h0101, res_ok, 4'h0, 32'h5, 0, ex(MFA_FLT_CONTACT_HI, 3'b000, 0));
		meas(res_ok, 16'h0101, 4'h0, 32'h5, 0, ex(MFA_FLT_CONTACT_LO, 3'b000, 0));
		meas(16'h0100, 16'h0100, 4'h0, 32'h5, 0, ex(MFA_FLT_NONE, 3'b010, 0));
		meas(res_ok, res_ok, 4'h1, 32'h5, 0, ex(MFA_FLT_VOLT, 3'b000, 0));
		meas(res_ok, res_ok, 4'h2, 32'h5, 0, ex(MFA_FLT_OVR_POS, 3'b100, 1));
		meas(16'h0200, res_ok, 4'h2, 32'h5, 0, ex(MFA_FLT_CONTACT_HI, 3'b000, 0));
		meas(res_ok, res_ok, 4'h3, 32'h5, 0, ex(MFA_FLT_VOLT, 3'b000, 0));
		meas(16'h0200, 16'h0200, 4'h1, 32'h5, 0, ex(MFA_FLT_CONTACT_HI, 3'b000, 0));
		meas(res_ok, res_ok, 4'h4, 32'hFFFF_FFFB, 0, ex(MFA_FLT_OVR_NEG, 3'b001, 0));
		meas(res_ok, res_ok, 4'h8, 32'h5, 0, ex(MFA_FLT_OVR_POS, 3'b100, 0));
		meas(res_ok, res_ok, 4'h0, 32'h5, 32'h000F_4240, ex(MFA_FLT_OVR_POS, 3'b100, 0));
		meas(res_ok, res_ok, 4'h0, 32'h5, 32'hFFF0_BDC0, ex(MFA_FLT_OVR_POS, 3'b100, 0));
		meas(res_ok, res_ok, 4'h0, 32'h5, `MFA_DEV_LIMIT, ex(MFA_FLT_NONE, 3'b010, 0));
		// Error status is set but masked, then unmasked, then cleared by writing a one
		chk(irq, 1'b0);
		axi_rd(`MFA_OFF_IRQ_STAT, 32'h7, 2'b00);
		axi_wr(`MFA_OFF_IRQ_MASK, 32'h2, 2'b00);
		repeat (2) @(negedge clk);
		chk(irq, 1'b1);
		axi_wr(`MFA_OFF_IRQ_STAT, 32'h2, 2'b00);
		repeat (2) @(negedge clk);
		chk(irq, 1'b0);
		axi_wr(`MFA_OFF_UPPER, 32'h64, 2'b00);
		@(negedge clk);
		chk({nr, fc}, {1'b1, MFA_FLT_NO_RESULT});
		// Only the two low byte lanes are enabled; the upper lanes land as zero
		wstrb <= 4'h3;
		axi_wr(`MFA_OFF_RANGE_MAX, 32'hFFFF_03E8, 2'b00);
		wstrb <= 4'hF;
		axi_rd(`MFA_OFF_RANGE_MAX, 32'h0000_03E8, 2'b00);
		meas(res_ok, res_ok, 4'h0, 32'h65, 0, ex(MFA_FLT_NONE, 3'b100, 0));
		meas(res_ok, res_ok, 4'h0, 32'h64, 0, ex(MFA_FLT_NONE, 3'b010, 0));
		meas(res_ok, res_ok, 4'h0, 32'hFFFF_FFFF, 0, ex(MFA_FLT_NONE, 3'b001, 0));
		meas(res_ok, res_ok, 4'h0, 32'h3E9, 0, ex(MFA_FLT_OVR_POS, 3'b100, 0));
		meas(res_ok, res_ok, 4'h0, 32'hFFFF_FC17, 0, ex(MFA_FLT_OVR_NEG, 3'b001, 0));
		// Comparator off gives no decision; contact check off lets a bad probe through
		axi_wr(`MFA_OFF_CTRL, 32'h6, 2'b00);
		meas(res_ok, res_ok, 4'h0, 32'h5, 0, ex(MFA_FLT_NONE, 3'b000, 0));
		axi_wr(`MFA_OFF_CTRL, 32'h5, 2'b00);
		meas(16'h0200, res_ok, 4'h0, 32'h5, 0, ex(MFA_FLT_NONE, 3'b010, 0));
		axi_rd(`MFA_OFF_VALUE, 32'h0000_0005, 2'b00);
		axi_rd(`MFA_OFF_STATUS, 32'h0000_0020, 2'b00);
		// A settings pulse from the engine side wipes the standing result
		@(posedge clk);
		sc <= 1'b1;
		@(posedge clk);
		sc <= 1'b0;
		@(negedge clk);
		chk({nr, fc}, {1'b1, MFA_FLT_NO_RESULT});
		axi_wr(`MFA_OFF_STATUS, 32'h1, 2'b10);
		axi_rd(8'h40, 32'h0, 2'b10);
		repeat (10) @(posedge clk);
		chk(q.size(), 0);
		test_done;
	end
endmodule
